// >>> hw/event_measure_timer_channel.sv
`include "evt_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Event mode edge field: 00 falling, 01 rising, 10 both pin edges.
// - Event mode decrements counter by one per detected effective pin edge.
// - Underflow reloads counter, sets request bit and overflow flag together.
// - Reload n gives one request per n+1 edges; counting continues alone.
// - Request bit stays set until accepted or cleared by software.
// - Down modes read the live counter; reload register is not readable in them.
// - Data write while counting goes to reload only, used at next underflow.
// - Mode code 10 selects pulse period or pulse width measurement.
// - Measurement counts the prescaled source only after start flag is one.
// - Measurement increments the counter by one per source pulse.
// - Effective edge copies counter to reload register, then clears counter.
// - Each capture raises a request, except the first edge after start.
// - Measurement mode reads return the captured reload register.
// - Interval field: 00 fall-fall, 01 rise-rise, 10 every level width.
// - Measurement wrap from all ones to zero raises request and overflow.
// - Capture and overflow share one request; overflow flag tells them apart.
// - Read at the reload instant in down modes returns all ones.
// - Read after data write while stopped, before first source pulse, returns written value.
// - Source field selects divide by 2, 16, 64, 512; ignored in event mode.
// - Overflow flag is one after reset, cleared by a mode register write unless an underflow or wrap sets it in that cycle.
module event_measure_timer_channel (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [`DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [`ADDR_W-1:0] s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [`DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               event_measure_input_pin,
   input  wire logic               irq_accept,
   output logic                    irq_request
);

   // Bus slave state
   logic                 awready_ff;
   logic                 wready_ff;
   logic                 bvalid_ff;
   logic [1:0]           bresp_ff;
   logic                 arready_ff;
   logic                 rvalid_ff;
   logic [1:0]           rresp_ff;
   logic [`DATA_W-1:0]   rdata_ff;
   logic                 aw_hold_ff;
   logic                 w_hold_ff;
   logic [`ADDR_W-1:0]   waddr_ff;
   logic [`DATA_W-1:0]   wdata_ff;
   logic [3:0]           wstrb_ff;
   logic                 nxt_aw_hold;
   logic                 nxt_w_hold;
   logic                 nxt_rvalid;
   logic                 aw_hs;
   logic                 w_hs;
   logic                 ar_hs;
   logic                 wr_go;
   evt_timer_pkg::reg_idx_t wr_idx;
   evt_timer_pkg::reg_idx_t rd_idx;

   // Timer state
   evt_timer_pkg::mode_t     mode_ff;
   evt_timer_pkg::edge_sel_t sel_ff;
   logic [1:0]           src_ff;
   logic                 ovf_ff;
   logic                 start_ff;
   logic                 first_edge_ff;
   logic                 irq_ff;
   logic [`CNT_W-1:0]    counter_ff;
   logic [`CNT_W-1:0]    reload_ff;

   // Datapath terms
   logic [3:0]           presc_en;
   logic                 pin_rise;
   logic                 pin_fall;
   logic                 eff_edge;
   logic                 src_tick;
   logic                 count_tick;
   logic                 down_mode;
   logic                 measure_mode;
   logic                 dn_reload;
   logic                 up_wrap;
   logic                 capture;
   logic                 wr_mode;
   logic                 wr_data;
   logic                 wr_start;
   logic                 wr_irq;
   logic [`CNT_W-1:0]    wr_value;
   logic [`CNT_W-1:0]    data_view;

   // Address decode for writes and reads
   function automatic evt_timer_pkg::reg_idx_t decode(input logic [`ADDR_W-1:0] addr);
      unique case (addr)
         `OFF_MODE:  decode = evt_timer_pkg::REG_MODE;
         `OFF_DATA:  decode = evt_timer_pkg::REG_DATA;
         `OFF_START: decode = evt_timer_pkg::REG_START;
         `OFF_IRQ:   decode = evt_timer_pkg::REG_IRQ;
         default:    decode = evt_timer_pkg::REG_NONE;
      endcase
   endfunction

   // Effective edge; same codes in both modes
   function automatic logic pick_edge(input evt_timer_pkg::edge_sel_t sel,
                                      input logic rise, input logic fall);
      unique case (sel)
         evt_timer_pkg::SEL_FALL: pick_edge = fall;
         evt_timer_pkg::SEL_RISE: pick_edge = rise;
         evt_timer_pkg::SEL_BOTH: pick_edge = rise | fall;
         default:                 pick_edge = 1'b0;
      endcase
   endfunction

   pin_edge_detect u_pin (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (event_measure_input_pin),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   osc_prescaler u_presc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick_en (presc_en)
   );

   // Handshakes; a write runs once address and data are held
   assign aw_hs       = s_axi_awvalid & awready_ff;
   assign w_hs        = s_axi_wvalid & wready_ff;
   assign ar_hs       = s_axi_arvalid & arready_ff;
   assign wr_go       = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   assign nxt_aw_hold = (aw_hold_ff | aw_hs) & ~wr_go;
   assign nxt_w_hold  = (w_hold_ff | w_hs) & ~wr_go;
   assign nxt_rvalid  = (rvalid_ff & ~s_axi_rready) | ar_hs;
   assign wr_idx      = decode(waddr_ff);
   assign rd_idx      = decode(s_axi_araddr);

   // Write address and data capture, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         waddr_ff   <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff  <= nxt_w_hold;
         awready_ff <= ~nxt_aw_hold;
         wready_ff  <= ~nxt_w_hold;
         if (aw_hs) begin
            waddr_ff <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wr_idx == evt_timer_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Write strobes per byte lane
   assign wr_mode  = wr_go & (wr_idx == evt_timer_pkg::REG_MODE) & wstrb_ff[0];
   assign wr_data  = wr_go & (wr_idx == evt_timer_pkg::REG_DATA) & (|wstrb_ff[1:0]);
   assign wr_start = wr_go & (wr_idx == evt_timer_pkg::REG_START) & wstrb_ff[0];
   assign wr_irq   = wr_go & (wr_idx == evt_timer_pkg::REG_IRQ) & wstrb_ff[0];
   assign wr_value = {wstrb_ff[1] ? wdata_ff[15:8] : reload_ff[15:8],
                      wstrb_ff[0] ? wdata_ff[7:0]  : reload_ff[7:0]};

   // Mode, selection and source fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= evt_timer_pkg::mode_t'(`MODE_RST);
         sel_ff  <= evt_timer_pkg::edge_sel_t'(`SEL_RST);
         src_ff  <= `SRC_RST;
      end else if (wr_mode) begin
         mode_ff <= evt_timer_pkg::mode_t'(wdata_ff[`MODE_LSB+1:`MODE_LSB]);
         sel_ff  <= evt_timer_pkg::edge_sel_t'(wdata_ff[`SEL_LSB+1:`SEL_LSB]);
         src_ff  <= wdata_ff[`SRC_LSB+1:`SRC_LSB];
      end
   end

   // Count start flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_ff <= 1'b0;
      end else if (wr_start) begin
         start_ff <= wdata_ff[`START_BIT];
      end
   end

   assign measure_mode = (mode_ff == evt_timer_pkg::MODE_MEASURE);
   assign down_mode    = (mode_ff == evt_timer_pkg::MODE_TIMER) |
                         (mode_ff == evt_timer_pkg::MODE_EVENT);

   // Effective edge from the two-bit field
   assign eff_edge = pick_edge(sel_ff, pin_rise, pin_fall);

   // Prescaled source, not used in event mode
   assign src_tick = presc_en[src_ff];

   // Count pulse per mode, gated by the start flag
   always_comb begin
      count_tick = 1'b0;
      if (start_ff) begin
         unique case (mode_ff)
            evt_timer_pkg::MODE_EVENT:   count_tick = eff_edge;
            evt_timer_pkg::MODE_TIMER:   count_tick = src_tick;
            evt_timer_pkg::MODE_MEASURE: count_tick = src_tick;
            default:                     count_tick = 1'b0;
         endcase
      end
   end

   // Underflow event in the down-counting modes
   assign dn_reload = count_tick & down_mode & (counter_ff == `CNT_RST);

   // Capture on the effective edge; it outranks a same-cycle wrap
   assign capture = start_ff & measure_mode & eff_edge;

   // Wrap from all ones to zero while measuring
   assign up_wrap = count_tick & measure_mode & (counter_ff == `CNT_ALL_ONES) & ~capture;

   // Counter: preload, capture, reload or count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_ff <= `CNT_RST;
      end else if (wr_data && !start_ff) begin
         // Preload while stopped so reads see the value
         counter_ff <= wr_value;
      end else if (capture) begin
         counter_ff <= `CNT_RST;
      end else if (dn_reload) begin
         counter_ff <= reload_ff;
      end else if (count_tick && down_mode) begin
         counter_ff <= counter_ff - 1'b1;
      end else if (count_tick && measure_mode) begin
         counter_ff <= counter_ff + 1'b1;
      end
   end

   // Reload register: software ratio or captured interval
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_ff <= `CNT_RST;
      end else if (capture) begin
         reload_ff <= counter_ff;
      end else if (wr_data) begin
         reload_ff <= wr_value;
      end
   end

   // First edge after start arms only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_edge_ff <= 1'b1;
      end else if (wr_start && wdata_ff[`START_BIT] && !start_ff) begin
         first_edge_ff <= 1'b1;
      end else if (capture) begin
         first_edge_ff <= 1'b0;
      end
   end

   // Overflow flag: set wins over the clear from a mode write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_ff <= `OVF_RST;
      end else if (dn_reload || up_wrap) begin
         ovf_ff <= 1'b1;
      end else if (wr_mode) begin
         ovf_ff <= 1'b0;
      end
   end

   // One shared request; hardware set beats any clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff <= 1'b0;
      end else if (dn_reload || up_wrap || (capture && !first_edge_ff)) begin
         irq_ff <= 1'b1;
      end else if (wr_irq) begin
         irq_ff <= wdata_ff[`IRQ_BIT];
      end else if (irq_accept) begin
         irq_ff <= 1'b0;
      end
   end

   // Data view: live count, captured value, or all ones
   always_comb begin
      if (measure_mode) begin
         data_view = reload_ff;
      end else if (dn_reload) begin
         data_view = `CNT_ALL_ONES;
      end else begin
         data_view = counter_ff;
      end
   end

   // Read channel; data sampled at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
         rdata_ff   <= '0;
         rresp_ff   <= `RESP_OKAY;
      end else begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= ~nxt_rvalid;
         if (ar_hs) begin
            rdata_ff <= '0;
            rresp_ff <= `RESP_OKAY;
            unique case (rd_idx)
               evt_timer_pkg::REG_MODE: begin
                  rdata_ff[`MODE_LSB+1:`MODE_LSB] <= mode_ff;
                  rdata_ff[`SEL_LSB+1:`SEL_LSB]   <= sel_ff;
                  rdata_ff[`OVF_BIT]              <= ovf_ff;
                  rdata_ff[`SRC_LSB+1:`SRC_LSB]   <= src_ff;
               end
               evt_timer_pkg::REG_DATA: begin
                  rdata_ff[`CNT_W-1:0] <= data_view;
               end
               evt_timer_pkg::REG_START: begin
                  rdata_ff[`START_BIT] <= start_ff;
               end
               evt_timer_pkg::REG_IRQ: begin
                  rdata_ff[`IRQ_BIT] <= irq_ff;
               end
               default: begin
                  rresp_ff <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // Outputs straight from flops
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign irq_request   = irq_ff;

endmodule

`default_nettype wire

// >>> hw/evt_timer_params.svh
`ifndef EVT_TIMER_PARAMS_SVH
`define EVT_TIMER_PARAMS_SVH

// Register bus geometry
`define ADDR_W          8
`define DATA_W          32
`define CNT_W           16

// Register byte offsets
`define OFF_MODE        8'h00
`define OFF_DATA        8'h04
`define OFF_START       8'h08
`define OFF_IRQ         8'h0c

// Mode register field positions
`define MODE_LSB        0
`define SEL_LSB         2
`define OVF_BIT         5
`define SRC_LSB         6

// Start and request register bit positions
`define START_BIT       0
`define IRQ_BIT         0

// Reset values
`define MODE_RST        2'h0
`define SEL_RST         2'h0
`define SRC_RST         2'h0
`define OVF_RST         1'b1
`define CNT_RST         16'h0000
`define CNT_ALL_ONES    16'hffff

// Prescaler: low counter bits all ones give divide by 2, 16, 64, 512
`define PRESC_W         9
`define DIV2_BITS       1
`define DIV16_BITS      4
`define DIV64_BITS      6
`define DIV512_BITS     9

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> hw/evt_timer_pkg.sv
package evt_timer_pkg;

   // Operating mode field codes
   typedef enum logic [1:0] {
      MODE_TIMER   = 2'h0,
      MODE_EVENT   = 2'h1,
      MODE_MEASURE = 2'h2,
      MODE_RSVD    = 2'h3
   } mode_t;

   // Edge or interval selection codes
   typedef enum logic [1:0] {
      SEL_FALL = 2'h0,
      SEL_RISE = 2'h1,
      SEL_BOTH = 2'h2,
      SEL_NONE = 2'h3
   } edge_sel_t;

   // Register index after address decode
   typedef enum logic [2:0] {
      REG_MODE,
      REG_DATA,
      REG_START,
      REG_IRQ,
      REG_NONE
   } reg_idx_t;

endpackage

// >>> hw/pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   output logic      rise,
   output logic      fall
);

   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;

   // Two-stage synchroniser plus a compare stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // Only the settled stages feed edge logic
   assign rise = sync2_ff & ~prev_ff;
   assign fall = ~sync2_ff & prev_ff;

endmodule

`default_nettype wire

// >>> hw/osc_prescaler.sv
`include "evt_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module osc_prescaler (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   output logic      [3:0] tick_en
);

   localparam int unsigned TAP_BITS [4] = '{`DIV2_BITS, `DIV16_BITS,
                                           `DIV64_BITS, `DIV512_BITS};

   logic [`PRESC_W-1:0] cnt_ff;

   // Free-running divider for all four rates
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // One-cycle enable when the low bits wrap
   genvar i;
   for (i = 0; i < 4; i++) begin : g_tap
      assign tick_en[i] = &cnt_ff[TAP_BITS[i]-1:0];
   end

endmodule

`default_nettype wire

// >>> tb/evt_timer_properties.sv
`include "evt_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module evt_timer_checker (
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [`DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic               irq_accept,
   input wire logic               irq_request
);
   // One domain: clock and reset stated once
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Bus timing
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_aw_block;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   // Refused reads leak nothing
   property p_bad_rd;
      s_axi_rvalid && (s_axi_rresp == `RESP_SLVERR) |-> (s_axi_rdata == 32'h0);
   endproperty
   // Request drops only on accept or write
   property p_irq_hold;
      $fell(irq_request) |-> $past(irq_accept) || $rose(s_axi_bvalid);
   endproperty

   a_rd_lat: assert property (p_rd_lat)
      else $error("late read answer");
   a_wr_lat: assert property (p_wr_lat)
      else $error("late write answer");
   a_ar_block: assert property (p_ar_block)
      else $error("read taken while busy");
   a_aw_block: assert property (p_aw_block)
      else $error("write taken twice");
   a_b_done: assert property (p_b_done)
      else $error("write answer repeated");
   a_r_done: assert property (p_r_done)
      else $error("read answer repeated");
   a_bad_rd: assert property (p_bad_rd)
      else $error("refused read data");
   a_irq_hold: assert property (p_irq_hold)
      else $error("request dropped");

   c_irq: cover property ($rose(irq_request));
   c_bad: cover property (s_axi_rvalid && (s_axi_rresp == `RESP_SLVERR));
   c_accept: cover property (irq_accept && irq_request);
endmodule

bind event_measure_timer_channel evt_timer_checker evt_timer_checker_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq_accept(irq_accept), .irq_request(irq_request)
);

`default_nettype wire

// >>> tb/pulse_source.sv
`timescale 1ns/1ps
`default_nettype none

module pulse_source (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       go,
   input  wire logic [3:0] toggles,
   input  wire logic [7:0] half,
   output logic            pin,
   output logic            busy
);
   logic       pin_ff;
   logic [3:0] left_ff;
   logic [7:0] wait_ff;

   // Pin keeps its level between runs
   // Minimum level hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_ff <= 1'b0;
         left_ff <= 4'h0;
         wait_ff <= 8'h0;
      end else if (go) begin
         left_ff <= toggles;
         wait_ff <= half;
      end else if (left_ff != 4'h0) begin
         if (wait_ff <= 8'h1) begin
            pin_ff <= ~pin_ff;
            left_ff <= left_ff - 4'h1;
            wait_ff <= half;
         end else begin
            wait_ff <= wait_ff - 8'h1;
         end
      end
   end

   assign pin = pin_ff;
   assign busy = go || (left_ff != 4'h0);
endmodule

`default_nettype wire

// >>> tb/event_measure_timer_channel_tb.sv
`include "evt_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module event_measure_timer_channel_tb;
   localparam int HALF = 8; // Four divide-by-two source cycles per level
   localparam logic [31:0] EV_CNT [3] = '{32'h1, 32'h0, 32'h2};
   localparam logic [1:0]  MS_SEL [3] = '{2'h1, 2'h0, 2'h2};
   localparam logic [3:0]  MS_N [3] = '{4'h2, 4'h2, 4'h1};
   localparam logic [31:0] MS_HI [3] = '{32'h8, 32'h8, 32'h4};
   logic               aclk, aresetn, irq_accept, irq_request, pin, go, busy;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic               s_axi_rvalid, s_axi_rready;
   logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [`DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]         s_axi_wstrb, toggles;
   logic [1:0]         s_axi_bresp, s_axi_rresp, r;
   int                 failures, checks_done;

   event_measure_timer_channel event_measure_timer_channel_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .event_measure_input_pin(pin), .irq_accept(irq_accept), .irq_request(irq_request)
   );
   pulse_source pulse_source_i (
      .aclk(aclk), .aresetn(aresetn), .go(go), .toggles(toggles), .half(8'(HALF)),
      .pin(pin), .busy(busy)
   );

   // Free-running bench clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Unknown bits fail both comparisons
   task check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks_done++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask

   // Address and data offered together, each dropped when taken
   task axi_wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask

   task axi_rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task launch(input logic [3:0] n);
      @(posedge aclk);
      toggles <= n;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
   endtask

   // Pin is seen three cycles late, hence the margin
   task settle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      repeat (8) @(posedge aclk);
   endtask

   task pulses(input logic [3:0] n);
      launch(n);
      settle;
   endtask

   task t_regs;
      axi_rd(`OFF_MODE);
      check(d, 32'h20);
      axi_rd(8'h10);
      check(32'(r), 32'(`RESP_SLVERR));
      check(d, 32'h0);
      axi_wr(8'h10, 32'h1);
      check(32'(r), 32'(`RESP_SLVERR));
      axi_wr(`OFF_MODE, 32'h1);
      axi_rd(`OFF_MODE);
      check(d, 32'h1);
      $display("test regs done");
   endtask

   // Three changes from low: one fall, two rises, three edges
   task t_event;
      for (int s = 0; s < 3; s++) begin
         axi_wr(`OFF_START, 32'h0);
         axi_wr(`OFF_MODE, 32'(s * 4 + 1));
         axi_wr(`OFF_DATA, 32'h2);
         axi_rd(`OFF_DATA);
         check(d, 32'h2);
         axi_wr(`OFF_IRQ, 32'h0);
         axi_wr(`OFF_START, 32'h1);
         pulses(4'h3);
         axi_rd(`OFF_DATA);
         check(d, EV_CNT[s]);
         check({31'h0, irq_request}, 32'(s == 2));
         axi_rd(`OFF_MODE);
         check(d, 32'(s * 4 + 1 + 32 * (s == 2)));
         axi_wr(`OFF_START, 32'h0);
         pulses(4'h1);
      end
      check({31'h0, irq_request}, 32'h1);
      @(posedge aclk);
      irq_accept <= 1'b1;
      @(posedge aclk);
      irq_accept <= 1'b0;
      @(posedge aclk);
      check({31'h0, irq_request}, 32'h0);
      $display("test event done");
   endtask

   task t_ratio;
      axi_wr(`OFF_MODE, 32'h9);
      axi_wr(`OFF_DATA, 32'h2);
      axi_wr(`OFF_IRQ, 32'h0);
      axi_wr(`OFF_START, 32'h1);
      axi_wr(`OFF_DATA, 32'h5);
      axi_rd(`OFF_DATA);
      check(d, 32'h2);
      pulses(4'h3);
      axi_rd(`OFF_DATA);
      check(d, 32'h5);
      check({31'h0, irq_request}, 32'h1);
      axi_wr(`OFF_START, 32'h0);
      pulses(4'h1);
      $display("test ratio done");
   endtask

   // Tick phase is unknown: one tick of slack
   task t_measure;
      for (int s = 0; s < 3; s++) begin
         axi_wr(`OFF_START, 32'h0);
         axi_wr(`OFF_MODE, 32'({MS_SEL[s], 2'h2}));
         axi_wr(`OFF_IRQ, 32'h0);
         axi_wr(`OFF_START, 32'h1);
         launch(4'h1 + MS_N[s]);
         repeat (HALF + 6) @(posedge aclk);
         check({31'h0, irq_request}, 32'h0);
         settle;
         check({31'h0, irq_request}, 32'h1);
         axi_rd(`OFF_DATA);
         check_in(d, MS_HI[s] - 32'h1, MS_HI[s]);
         axi_rd(`OFF_MODE);
         check(d, 32'({MS_SEL[s], 2'h2}));
      end
      $display("test measure done");
   endtask

   task test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, toggles, go, irq_accept} = '0;
      s_axi_wstrb = 4'hf;
      failures = 0;
      checks_done = 0;
      aresetn = 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_event;
      t_ratio;
      t_measure;
      test_done;
   end

   // Tests need well under a thousand cycles; this cuts a hang
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      test_done;
   end
endmodule

`default_nettype wire
